// ===== logic/cxe_decrementer.sv
`timescale 1ns/1ps
module cxe_decrementer
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic dec_write,
  input wire logic [31:0] dec_wdata,
  input wire logic dec_taken,
  output logic [31:0] dec_count,
  output logic dec_pending
);
  import cxe_pkg::*;

  logic [31:0] count_next;
  logic bit0_rise;

  ////////////////////////////////////////////////////////////////////////
  // next count: write replaces, else count down
  always_comb begin
    if (dec_write) begin
      count_next = dec_wdata;
    end else begin
      count_next = dec_count - 32'h0000_0001;
    end
  end

  // msb is documented bit 0
  assign bit0_rise = !dec_count[31] && count_next[31];

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_count <= DEC_RST;
    end else begin
      dec_count <= count_next;
    end
  end

  // sticky request, set wins over take
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_pending <= 1'b0;
    end else if (bit0_rise) begin
      dec_pending <= 1'b1;
    end else if (dec_taken) begin
      dec_pending <= 1'b0;
    end
  end

  // every rise of the top bit leaves a request behind
  property p_dec_rise;
    @(posedge ref_clk) disable iff (sys_rst)
    (!dec_count[31] && count_next[31]) |=> dec_pending;
  endproperty
  a_dec_rise: assert property (p_dec_rise)
    else $error("decrementer edge did not set request");

  // a request not yet taken is kept
  property p_dec_merge;
    @(posedge ref_clk) disable iff (sys_rst)
    (dec_pending && !dec_taken) |=> dec_pending;
  endproperty
  a_dec_merge: assert property (p_dec_merge)
    else $error("pending decrementer request lost");
endmodule // cxe_decrementer

// ===== logic/cxe_exception_entry.sv
`timescale 1ns/1ps
// Behaviour
// - fp instruction with fp disabled raises exception
// - fp entry saves faulting address, upper state
// - entry keeps base select, machine check enable; copies handler order
// - fp unavailable vectors to 0x00800
// - decrementer taken only with interrupts enabled
// - decrementer counts down; write replaces count
// - request on decrementer top bit rising
// - requests merge; taking clears pending
// - decrementer saves next address, upper state
// - decrementer vectors to 0x00900
// - system call saves following address, upper state
// - system call drains pipeline before entry
// - system call vectors to 0x00c00
// - trace on single step or branch completion
// - no trace after excepting instruction
// - trace saves following address, upper state
// - trace vectors to 0x00d00
module cxe_exception_entry
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic instr_valid,
  input wire logic [31:0] instr_addr,
  input wire logic [31:0] next_addr,
  input wire logic instr_is_fp,
  input wire logic instr_is_sc,
  input wire logic instr_is_rfi,
  input wire logic instr_is_branch,
  input wire logic instr_done,
  input wire logic instr_excepted,
  input wire logic pipe_empty,
  input wire logic higher_pending,
  input wire logic msw_write,
  input wire logic [31:0] msw_wdata,
  input wire logic dec_write,
  input wire logic [31:0] dec_wdata,
  output logic [31:0] machine_state_word,
  output logic [31:0] saved_return_address,
  output logic [31:0] saved_machine_state,
  output logic [31:0] dec_value,
  output logic fetch_redirect,
  output logic [31:0] fetch_addr,
  output logic dispatch_stall,
  output logic fp_fault_taken
);
  import cxe_pkg::*;

  logic [31:0] dec_count;
  logic dec_pending;
  logic dec_taken;
  logic sc_wait_reg;
  logic [31:0] sc_ret_reg;
  logic fpu_cond;
  logic sc_cond;
  logic trc_cond;
  logic dec_cond;
  cxe_kind_t kind_next;
  logic [31:0] ret_next;
  logic [31:0] base_next;
  logic [31:0] vec_next;
  logic [31:0] msw_entry;
  logic [31:0] saved_machine_state_entry;

  ////////////////////////////////////////////////////////////////////////
  // decrementer and its request latch
  cxe_decrementer u_dec (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .dec_write(dec_write),
    .dec_wdata(dec_wdata),
    .dec_taken(dec_taken),
    .dec_count(dec_count),
    .dec_pending(dec_pending)
  );

  ////////////////////////////////////////////////////////////////////////
  // condition detection
  assign fpu_cond = instr_valid && instr_is_fp && !machine_state_word[MS_FP]
                    && !higher_pending;
  assign sc_cond = sc_wait_reg && pipe_empty && !higher_pending;
  assign trc_cond = instr_done && !instr_excepted && !higher_pending
                    && ((machine_state_word[MS_SE] && !instr_is_rfi)
                    || (machine_state_word[MS_BE] && instr_is_branch));
  assign dec_cond = dec_pending && machine_state_word[MS_EE] && !higher_pending;

  // fixed priority choice of one exception
  always_comb begin
    kind_next = CXE_NONE;
    ret_next = ADDR_RST;
    vec_next = ADDR_RST;
    if (fpu_cond) begin
      kind_next = CXE_FPU;
      ret_next = instr_addr;
      vec_next = VEC_FPU;
    end else if (sc_cond) begin
      kind_next = CXE_SC;
      ret_next = sc_ret_reg;
      vec_next = VEC_SC;
    end else if (trc_cond) begin
      kind_next = CXE_TRC;
      ret_next = next_addr;
      vec_next = VEC_TRC;
    end else if (dec_cond) begin
      kind_next = CXE_DEC;
      ret_next = next_addr;
      vec_next = VEC_DEC;
    end
  end

  assign dec_taken = (kind_next == CXE_DEC);
  assign base_next = machine_state_word[MS_IP] ? BASE_HIGH : BASE_LOW;

  // new state word and saved state on entry
  always_comb begin
    msw_entry = MSW_RST;
    msw_entry[MS_IP] = machine_state_word[MS_IP];
    msw_entry[MS_ME] = machine_state_word[MS_ME];
    msw_entry[MS_LE] = machine_state_word[MS_HLE];
    saved_machine_state_entry = {16'h0000, machine_state_word[15:0]};
  end

  ////////////////////////////////////////////////////////////////////////
  // system call: hold dispatch until in-flight work drains
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sc_wait_reg <= 1'b0;
      sc_ret_reg <= ADDR_RST;
    end else if (instr_valid && instr_is_sc && !sc_wait_reg) begin
      sc_wait_reg <= 1'b1;
      sc_ret_reg <= next_addr;
    end else if (kind_next == CXE_SC) begin
      sc_wait_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dispatch_stall <= 1'b0;
    end else begin
      dispatch_stall <= (sc_wait_reg && kind_next != CXE_SC)
                        || (instr_valid && instr_is_sc);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // machine state word: entry overrides software write
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      machine_state_word <= MSW_RST;
    end else if (kind_next != CXE_NONE) begin
      machine_state_word <= msw_entry;
    end else if (msw_write) begin
      machine_state_word <= msw_wdata;
    end
  end

  // save registers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      saved_return_address <= ADDR_RST;
      saved_machine_state <= MSW_RST;
    end else if (kind_next != CXE_NONE) begin
      saved_return_address <= ret_next;
      saved_machine_state <= saved_machine_state_entry;
    end
  end

  // fetch redirect, one-cycle pulse
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_redirect <= 1'b0;
      fetch_addr <= ADDR_RST;
      fp_fault_taken <= 1'b0;
    end else begin
      fetch_redirect <= (kind_next != CXE_NONE);
      fetch_addr <= base_next | vec_next;
      fp_fault_taken <= (kind_next == CXE_FPU);
    end
  end

  // decrementer value mirror
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dec_value <= DEC_RST;
    end else begin
      dec_value <= dec_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_fpu_vec;
    @(posedge ref_clk) disable iff (sys_rst)
    fpu_cond |=> fetch_redirect && fetch_addr[19:0] == VEC_FPU[19:0]
      && saved_return_address == $past(instr_addr);
  endproperty
  a_fpu_vec: assert property (p_fpu_vec)
    else $error("fp unavailable entry wrong");

  // fault flag follows the fp entry
  property p_fp_flag;
    @(posedge ref_clk) disable iff (sys_rst)
    fpu_cond |=> fp_fault_taken;
  endproperty
  a_fp_flag: assert property (p_fp_flag)
    else $error("fp fault flag missing");

  property p_entry_msw;
    @(posedge ref_clk) disable iff (sys_rst)
    (kind_next != CXE_NONE) |=> machine_state_word[MS_LE] == $past(machine_state_word[MS_HLE])
      && machine_state_word[MS_IP] == $past(machine_state_word[MS_IP])
      && machine_state_word[MS_EE] == 1'b0;
  endproperty
  a_entry_msw: assert property (p_entry_msw)
    else $error("state word not set on entry");

  // entry clears the enables it does not keep
  property p_entry_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    (kind_next != CXE_NONE) |=> machine_state_word[MS_ME] == $past(machine_state_word[MS_ME])
      && !machine_state_word[MS_FP] && !machine_state_word[MS_SE] && !machine_state_word[MS_BE];
  endproperty
  a_entry_clear: assert property (p_entry_clear)
    else $error("state word enables not cleared on entry");

  property p_saved_machine_state;
    @(posedge ref_clk) disable iff (sys_rst)
    (kind_next != CXE_NONE) |=> saved_machine_state[15:0] == $past(machine_state_word[15:0])
      && saved_machine_state[31:16] == 16'h0000;
  endproperty
  a_saved_machine_state: assert property (p_saved_machine_state)
    else $error("saved state wrong");

  property p_dec_mask;
    @(posedge ref_clk) disable iff (sys_rst)
    !machine_state_word[MS_EE] |-> kind_next != CXE_DEC;
  endproperty
  a_dec_mask: assert property (p_dec_mask)
    else $error("masked decrementer taken");

  property p_dec_vec;
    @(posedge ref_clk) disable iff (sys_rst)
    (kind_next == CXE_DEC) |=> fetch_redirect && fetch_addr[19:0] == VEC_DEC[19:0]
      && saved_return_address == $past(next_addr);
  endproperty
  a_dec_vec: assert property (p_dec_vec)
    else $error("decrementer vector wrong");

  // software write replaces the count
  property p_dec_load;
    @(posedge ref_clk) disable iff (sys_rst)
    dec_write |=> dec_count == $past(dec_wdata);
  endproperty
  a_dec_load: assert property (p_dec_load)
    else $error("decrementer write lost");

  // otherwise the count steps down by one
  property p_dec_down;
    @(posedge ref_clk) disable iff (sys_rst)
    !dec_write |=> dec_count == $past(dec_count) - 32'h0000_0001;
  endproperty
  a_dec_down: assert property (p_dec_down)
    else $error("decrementer did not count down");

  // taking the exception clears the request when no new edge comes
  property p_dec_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    (kind_next == CXE_DEC && dec_count[31]) |=> !dec_pending;
  endproperty
  a_dec_clear: assert property (p_dec_clear)
    else $error("decrementer request not cleared");

  property p_sc_vec;
    @(posedge ref_clk) disable iff (sys_rst)
    (kind_next == CXE_SC) |=> fetch_addr[19:0] == VEC_SC[19:0]
      && saved_return_address == $past(sc_ret_reg);
  endproperty
  a_sc_vec: assert property (p_sc_vec)
    else $error("system call entry wrong");

  property p_sc_wait;
    @(posedge ref_clk) disable iff (sys_rst)
    (sc_wait_reg && !pipe_empty) |-> kind_next != CXE_SC ##1 dispatch_stall;
  endproperty
  a_sc_wait: assert property (p_sc_wait)
    else $error("system call entered before drain");

  // system call latches the following address and stalls dispatch
  property p_sc_ret;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_valid && instr_is_sc && !sc_wait_reg) |=> sc_ret_reg == $past(next_addr)
      && dispatch_stall;
  endproperty
  a_sc_ret: assert property (p_sc_ret)
    else $error("system call return address not held");

  property p_trc;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_done && instr_excepted && !fpu_cond && !sc_cond && !dec_cond) |=> !fetch_redirect;
  endproperty
  a_trc: assert property (p_trc)
    else $error("trace after excepting instruction");

  // branch trace raised when nothing higher is taken
  property p_trc_branch;
    @(posedge ref_clk) disable iff (sys_rst)
    (instr_done && !instr_excepted && !higher_pending && machine_state_word[MS_BE]
      && instr_is_branch && !fpu_cond && !sc_cond) |=> fetch_redirect
      && fetch_addr[19:0] == VEC_TRC[19:0];
  endproperty
  a_trc_branch: assert property (p_trc_branch)
    else $error("branch trace not taken");

  // a higher exception blocks every entry here
  property p_hp_block;
    @(posedge ref_clk) disable iff (sys_rst)
    higher_pending |=> !fetch_redirect;
  endproperty
  a_hp_block: assert property (p_hp_block)
    else $error("entry taken under higher exception");

  property p_trc_vec;
    @(posedge ref_clk) disable iff (sys_rst)
    (kind_next == CXE_TRC) |=> fetch_addr[19:0] == VEC_TRC[19:0]
      && saved_return_address == $past(next_addr);
  endproperty
  a_trc_vec: assert property (p_trc_vec)
    else $error("trace entry wrong");

  property p_prio;
    @(posedge ref_clk) disable iff (sys_rst)
    (fpu_cond && dec_cond) |-> kind_next == CXE_FPU ##1 dec_pending;
  endproperty
  a_prio: assert property (p_prio)
    else $error("priority order broken");

  // main scenarios reached
  c_fpu: cover property (@(posedge ref_clk) disable iff (sys_rst) kind_next == CXE_FPU);
  c_dec: cover property (@(posedge ref_clk) disable iff (sys_rst) kind_next == CXE_DEC);
  c_sc: cover property (@(posedge ref_clk) disable iff (sys_rst) kind_next == CXE_SC);
  c_trc: cover property (@(posedge ref_clk) disable iff (sys_rst) kind_next == CXE_TRC);
  c_prio: cover property (@(posedge ref_clk) disable iff (sys_rst) fpu_cond && dec_cond);
endmodule // cxe_exception_entry

// ===== logic/cxe_pkg.sv
package cxe_pkg;
  // machine state bit positions, little-endian index = 31 - documented big-endian bit
  localparam int MS_EE = 15;   // external_interrupt_enable (bit 16)
  localparam int MS_FP = 13;   // float_unit_available (bit 18)
  localparam int MS_ME = 12;   // machine_check_enable (bit 19)
  localparam int MS_SE = 10;   // single_step_trace_enable (bit 21)
  localparam int MS_BE = 9;    // branch_trace_enable (bit 22)
  localparam int MS_IP = 6;    // vector_base_select (bit 25)
  localparam int MS_LE = 0;    // byte_order_bit (bit 31)
  localparam int MS_HLE = 16;  // handler_byte_order (bit 15)
  // vector offsets
  localparam logic [31:0] VEC_FPU = 32'h0000_0800;
  localparam logic [31:0] VEC_DEC = 32'h0000_0900;
  localparam logic [31:0] VEC_SC = 32'h0000_0c00;
  localparam logic [31:0] VEC_TRC = 32'h0000_0d00;
  // physical bases chosen by vector_base_select
  localparam logic [31:0] BASE_LOW = 32'h0000_0000;
  localparam logic [31:0] BASE_HIGH = 32'hfff0_0000;
  // reset values
  localparam logic [31:0] MSW_RST = 32'h0000_0000;
  localparam logic [31:0] DEC_RST = 32'hffff_ffff;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  // exception kinds in priority order
  typedef enum logic [2:0] {
    CXE_NONE, CXE_FPU, CXE_SC, CXE_TRC, CXE_DEC
  } cxe_kind_t;
endpackage

// ===== test/cxe_tb.sv
`timescale 1ns/1ps
module tb;
  import cxe_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic instr_valid = 1'b0, instr_is_fp = 1'b0, instr_is_sc = 1'b0, instr_is_rfi = 1'b0;
  logic instr_is_branch = 1'b0, instr_done = 1'b0, instr_excepted = 1'b0;
  logic pipe_empty = 1'b1, higher_pending = 1'b0, msw_write = 1'b0, dec_write = 1'b0;
  logic [31:0] instr_addr = 32'h0, next_addr = 32'h0, msw_wdata = 32'h0, dec_wdata = 32'h0;
  logic [31:0] machine_state_word, saved_return_address, saved_machine_state, dec_value;
  logic [31:0] fetch_addr;
  logic fetch_redirect, dispatch_stall, fp_fault_taken;
  int error_cnt = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // free-running core clock
  always #5 ref_clk = ~ref_clk;
  cxe_exception_entry i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_addr(instr_addr), .next_addr(next_addr), .instr_is_fp(instr_is_fp),
    .instr_is_sc(instr_is_sc), .instr_is_rfi(instr_is_rfi), .instr_is_branch(instr_is_branch),
    .instr_done(instr_done), .instr_excepted(instr_excepted), .pipe_empty(pipe_empty),
    .higher_pending(higher_pending), .msw_write(msw_write), .msw_wdata(msw_wdata),
    .dec_write(dec_write), .dec_wdata(dec_wdata), .machine_state_word(machine_state_word),
    .saved_return_address(saved_return_address), .saved_machine_state(saved_machine_state),
    .dec_value(dec_value), .fetch_redirect(fetch_redirect), .fetch_addr(fetch_addr),
    .dispatch_stall(dispatch_stall), .fp_fault_taken(fp_fault_taken));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // machine state after entry: base select and machine check kept, order from handler bit
  function automatic logic [31:0] exp_msw(input logic [31:0] m);
    logic [31:0] r;
    r = 32'h0;
    r[MS_ME] = m[MS_ME];
    r[MS_IP] = m[MS_IP];
    r[MS_LE] = m[MS_HLE];
    return r;
  endfunction
  task automatic set_msw(input logic [31:0] v);
    @(posedge ref_clk) msw_write <= 1'b1;
    msw_wdata <= v;
    @(posedge ref_clk) msw_write <= 1'b0;
    #1 chk("msw write", v, machine_state_word);
  endtask
  // one issuing instruction for a single cycle, flags as {fp,sc,rfi,br,done,exc}
  task automatic issue(input logic [5:0] f, input logic [31:0] a, input logic [31:0] n);
    @(posedge ref_clk) instr_valid <= 1'b1;
    {instr_is_fp, instr_is_sc, instr_is_rfi, instr_is_branch, instr_done, instr_excepted} <= f;
    instr_addr <= a;
    next_addr <= n;
    @(posedge ref_clk) instr_valid <= 1'b0;
    {instr_is_fp, instr_is_sc, instr_is_rfi, instr_is_branch, instr_done, instr_excepted} <= 6'h0;
    #1;
  endtask
  task automatic no_redir(input int n);
    chk("no redirect", 32'h0, {31'h0, fetch_redirect});
    repeat (n) begin
      @(posedge ref_clk) #1 chk("no redirect", 32'h0, {31'h0, fetch_redirect});
    end
  endtask
  task automatic wait_redir(input int n);
    for (int i = 0; i < n && fetch_redirect !== 1'b1; i++) @(posedge ref_clk) #1;
  endtask
  task automatic chk_entry(input logic [31:0] vec, input logic [31:0] sra, input logic [31:0] m);
    chk("redirect", 32'h1, {31'h0, fetch_redirect});
    chk("fetch addr", (m[MS_IP] ? BASE_HIGH : BASE_LOW) | vec, fetch_addr);
    chk("saved addr", sra, saved_return_address);
    chk("saved state", {16'h0, m[15:0]}, saved_machine_state);
    chk("entry state", exp_msw(m), machine_state_word);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_fp();
    logic [31:0] m;
    m = 32'h1 << MS_HLE | 32'h1 << MS_ME | 32'h1 << MS_IP | 32'h1 << MS_SE | 32'h4;
    set_msw(m);
    @(posedge ref_clk) higher_pending <= 1'b1;
    issue(6'h20, 32'h0000_1000, 32'h0000_1004);
    no_redir(2);
    @(posedge ref_clk) higher_pending <= 1'b0;
    issue(6'h28, 32'h0000_2000, 32'h0000_2004);
    chk_entry(VEC_FPU, 32'h0000_2000, m);
    chk("fp taken", 32'h1, {31'h0, fp_fault_taken});
    set_msw(32'h1 << MS_FP);
    issue(6'h20, 32'h0000_3000, 32'h0000_3004);
    no_redir(2);
    $display("test fp done");
  endtask
  task automatic t_sc();
    logic [31:0] m;
    m = 32'h1 << MS_EE | 32'h1 << MS_ME | 32'h8;
    set_msw(m);
    @(posedge ref_clk) pipe_empty <= 1'b0;
    issue(6'h10, 32'h0000_5000, 32'h0000_5004);
    repeat (3) begin
      @(posedge ref_clk) #1 chk("stall", 32'h1, {31'h0, dispatch_stall});
      chk("early redirect", 32'h0, {31'h0, fetch_redirect});
    end
    @(posedge ref_clk) pipe_empty <= 1'b1;
    #1 wait_redir(4);
    chk_entry(VEC_SC, 32'h0000_5004, m);
    @(posedge ref_clk) #1 chk("stall off", 32'h0, {31'h0, dispatch_stall});
    $display("test sc done");
  endtask
  task automatic t_trace();
    logic [31:0] m;
    m = 32'h1 << MS_SE | 32'h1 << MS_IP;
    set_msw(m);
    issue(6'h0a, 32'h0000_6000, 32'h0000_6004);
    no_redir(1);
    issue(6'h03, 32'h0000_6100, 32'h0000_6104);
    no_redir(1);
    issue(6'h02, 32'h0000_6200, 32'h0000_6204);
    chk_entry(VEC_TRC, 32'h0000_6204, m);
    m = 32'h1 << MS_BE;
    set_msw(m);
    issue(6'h02, 32'h0000_6300, 32'h0000_6304);
    no_redir(1);
    issue(6'h06, 32'h0000_6400, 32'h0000_6480);
    chk_entry(VEC_TRC, 32'h0000_6480, m);
    $display("test trace done");
  endtask
  task automatic t_dec();
    logic [31:0] m;
    m = 32'h1 << MS_EE | 32'h1 << MS_HLE;
    @(posedge ref_clk) next_addr <= 32'h0000_7700;
    dec_write <= 1'b1;
    dec_wdata <= 32'h0000_0100;
    @(posedge ref_clk) dec_write <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk("dec runs", 32'h1, {31'h0, dec_value < 32'h100 && dec_value > 32'hf0});
    @(posedge ref_clk) dec_write <= 1'b1;
    dec_wdata <= 32'h0;
    @(posedge ref_clk) dec_write <= 1'b0;
    #1 no_redir(6);
    set_msw(m);
    wait_redir(4);
    chk_entry(VEC_DEC, 32'h0000_7700, m);
    set_msw(m);
    no_redir(6);
    $display("test dec done");
  endtask
  // one software write of the decrementer, landing at the second edge
  task automatic dec_wr(input logic [31:0] v);
    @(posedge ref_clk) dec_write <= 1'b1;
    dec_wdata <= v;
    @(posedge ref_clk) dec_write <= 1'b0;
  endtask
  // two merged requests wait behind an fp entry, then one decrementer entry
  task automatic t_prio();
    logic [31:0] m;
    m = 32'h1 << MS_EE;
    set_msw(32'h0);
    dec_wr(32'h0000_0040);
    @(posedge ref_clk) #1 chk("dec load", 32'h0000_0040, dec_value);
    dec_wr(32'h8000_0000);
    dec_wr(32'h0000_0000);
    @(posedge ref_clk) higher_pending <= 1'b1;
    set_msw(m);
    @(posedge ref_clk) higher_pending <= 1'b0;
    instr_valid <= 1'b1;
    instr_is_fp <= 1'b1;
    instr_addr <= 32'h0000_8000;
    next_addr <= 32'h0000_8004;
    @(posedge ref_clk) instr_valid <= 1'b0;
    instr_is_fp <= 1'b0;
    #1 chk_entry(VEC_FPU, 32'h0000_8000, m);
    set_msw(m);
    wait_redir(4);
    chk_entry(VEC_DEC, 32'h0000_8004, m);
    chk("fp taken", 32'h0, {31'h0, fp_fault_taken});
    set_msw(m);
    no_redir(4);
    $display("test prio done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence after reset
  initial begin
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1 chk("reset msw", MSW_RST, machine_state_word);
    chk("reset addr", ADDR_RST, saved_return_address);
    t_fp();
    t_sc();
    t_trace();
    t_dec();
    t_prio();
    stop_test();
  end
  // watchdog against a hang
  initial begin
    #100us error_cnt++;
    stop_test();
  end
endmodule // tb
